/* File: hw/sccd_clock_control.sv */
// Slow clock, bus ratio, USB and camera clock divider control with AHB-Lite registers
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - USB gate bit low: power, lock-wait, enable usb_clock
// - Main PLL off only with power-down and slow
// - Slow select low: core clock follows main PLL
// - Slow core clock: input over twice divider value, undivided at zero
// - Slow source is the crystal or external input
// - Halve bit halves usb_clock from USB PLL
// - Bus ratio codes give divide 1, 2, 4/8
// - Bus ratio code three gives divide 3/6
// - Peripheral clock is bus clock or half
// - Core clocked by core or bus clock
// - Camera clock is USB PLL or divided
// - Camera divide is twice (divisor plus one)
// - USB lock wait timed by lock count value
module sccd_clock_control (
    input  wire logic                  sys_clk_i,
    input  wire logic                  srst_i,
    input  wire logic                  hsel_i,
    input  wire logic [31:0]           haddr_i,
    input  wire logic [1:0]            htrans_i,
    input  wire logic                  hwrite_i,
    input  wire logic [2:0]            hsize_i,
    input  wire logic [31:0]           hwdata_i,
    input  wire logic                  hready_i,
    output logic [31:0]                hrdata_o,
    output logic                       hreadyout_o,
    output logic                       hresp_o,
    input  wire sccd_pkg::sccd_src_type src_tick_i,
    input  wire logic [15:0]           usb_pll_lock_count_i,
    output sccd_pkg::sccd_clk_type     clk_en_o,
    output logic                       main_pll_power_down_o,
    output logic                       usb_pll_power_down_o
);
    import sccd_pkg::*;

    sccd_slow_type      slow_q, slow_d;
    sccd_ratio_type     ratio_q, ratio_d;
    sccd_cam_type       cam_q, cam_d;
    logic               dp_wr_q, dp_wr_d;
    logic [7:0]         dp_addr_q, dp_addr_d;
    logic [31:0]        rdata_q, rdata_d;
    logic               slow_act_q, slow_act_d;
    logic [3:0]         slow_cnt_q, slow_cnt_d;
    logic [3:0]         bus_cnt_q, bus_cnt_d;
    logic               per_cnt_q, per_cnt_d;
    logic               cpu_bus_q, cpu_bus_d;
    sccd_usb_state_type usb_st_q, usb_st_d;
    logic [15:0]        lock_cnt_q, lock_cnt_d;
    logic               usb_cnt_q, usb_cnt_d;
    logic [4:0]         cam_cnt_q, cam_cnt_d;
    sccd_clk_type       clk_q, clk_d;
    logic               core_tick;
    logic               bus_tick;
    logic               per_tick;
    logic               usb_tick;
    logic               cam_tick;
    logic               upll_ok;
    logic               ap_valid;
    logic [31:0]        status_word;

    // Bus divide factor for the current ratio code and halving bits
    function automatic logic [3:0] bus_factor(input sccd_ratio_type r, input sccd_cam_type c);
        logic [3:0] f;
        f = SCCD_F1;
        unique case (r.bus_clock_ratio)
            SCCD_BUS_DIV1: f = SCCD_F1;
            SCCD_BUS_DIV2: f = SCCD_F2;
            SCCD_BUS_DIV4: f = c.quarter_ratio_halve ? SCCD_F8 : SCCD_F4;
            SCCD_BUS_DIV3: f = c.third_ratio_halve ? SCCD_F6 : SCCD_F3;
        endcase
        return f;
    endfunction

    // Register word packing, reserved bits read zero
    function automatic logic [31:0] read_word(input logic [7:0] a, input sccd_slow_type s,
                                              input sccd_ratio_type r, input sccd_cam_type c,
                                              input logic [31:0] st);
        logic [31:0] w;
        w = SCCD_ZERO_WORD;
        if (a == SCCD_SLOW_OFS[SCCD_DEC_MSB:0]) begin
            w[SCCD_USB_GATE_POS]                    = s.usb_clock_gate_bit;
            w[SCCD_MPLL_PD_POS]                     = s.main_pll_power_down;
            w[SCCD_SLOW_SEL_POS]                    = s.slow_mode_select;
            w[SCCD_SLOW_DIV_LSB+:3]                 = s.slow_divider_value;
        end else if (a == SCCD_RATIO_OFS[SCCD_DEC_MSB:0]) begin
            w[SCCD_USB_HALVE_POS]                   = r.usb_clock_halve;
            w[SCCD_BUS_RATIO_LSB+:2]                = r.bus_clock_ratio;
            w[SCCD_PER_RATIO_POS]                   = r.peripheral_clock_ratio;
        end else if (a == SCCD_CAM_OFS[SCCD_DEC_MSB:0]) begin
            w[SCCD_CORE_BUS_POS]                    = c.core_on_bus_clock;
            w[SCCD_QUART_HV_POS]                    = c.quarter_ratio_halve;
            w[SCCD_THIRD_HV_POS]                    = c.third_ratio_halve;
            w[SCCD_CAM_SEL_POS]                     = c.camera_clock_divide_select;
            w[SCCD_CAM_DIV_LSB+:4]                  = c.camera_clock_divisor;
        end else if (a == SCCD_STAT_OFS[SCCD_DEC_MSB:0]) begin
            w = st;
        end
        return w;
    endfunction

    // Address phase qualifier and fixed responses; no wait states keeps the
    // bus side simple at the cost of a combinational read path into rdata_q
    assign ap_valid    = hsel_i && hready_i && htrans_i[SCCD_HTRANS_ACT];
    assign hreadyout_o = 1'b1;  // Zero wait states, every access completes at once
    assign hresp_o     = 1'b0;  // Always OKAY, unmapped reads give zero
    assign hrdata_o    = rdata_q;

    // Live status of the generator, readable by software
    always_comb begin
        status_word                     = SCCD_ZERO_WORD;
        status_word[SCCD_ST_LOCK_POS]   = (usb_st_q == SCCD_USB_RUN);
        status_word[SCCD_ST_SLOW_POS]   = slow_act_q;
        status_word[SCCD_ST_MOFF_POS]   = main_pll_power_down_o;
        status_word[SCCD_ST_CPUBUS_POS] = cpu_bus_q;
    end

    // Bus slave: writes land in the data phase; reads are taken from the next-state
    // values so a read right behind a write to the same register sees the new data
    always_comb begin
        slow_d    = slow_q;
        ratio_d   = ratio_q;
        cam_d     = cam_q;
        dp_wr_d   = ap_valid && hwrite_i;
        dp_addr_d = haddr_i[SCCD_DEC_MSB:0];
        rdata_d   = rdata_q;
        if (dp_wr_q) begin
            if (dp_addr_q == SCCD_SLOW_OFS[SCCD_DEC_MSB:0]) begin
                slow_d.usb_clock_gate_bit  = hwdata_i[SCCD_USB_GATE_POS];
                slow_d.main_pll_power_down = hwdata_i[SCCD_MPLL_PD_POS];
                slow_d.slow_mode_select    = hwdata_i[SCCD_SLOW_SEL_POS];
                slow_d.slow_divider_value  = hwdata_i[SCCD_SLOW_DIV_LSB+:3];
            end
            if (dp_addr_q == SCCD_RATIO_OFS[SCCD_DEC_MSB:0]) begin
                ratio_d.usb_clock_halve        = hwdata_i[SCCD_USB_HALVE_POS];
                ratio_d.bus_clock_ratio        = hwdata_i[SCCD_BUS_RATIO_LSB+:2];
                ratio_d.peripheral_clock_ratio = hwdata_i[SCCD_PER_RATIO_POS];
            end
            if (dp_addr_q == SCCD_CAM_OFS[SCCD_DEC_MSB:0]) begin
                cam_d.core_on_bus_clock          = hwdata_i[SCCD_CORE_BUS_POS];
                cam_d.quarter_ratio_halve        = hwdata_i[SCCD_QUART_HV_POS];
                cam_d.third_ratio_halve          = hwdata_i[SCCD_THIRD_HV_POS];
                cam_d.camera_clock_divide_select = hwdata_i[SCCD_CAM_SEL_POS];
                cam_d.camera_clock_divisor       = hwdata_i[SCCD_CAM_DIV_LSB+:4];
            end
        end
        if (ap_valid && !hwrite_i) begin
            rdata_d = read_word(haddr_i[SCCD_DEC_MSB:0], slow_d, ratio_d, cam_d, status_word);
        end
    end

    // Register and data-phase flops; only the slow divider field resets
    // to a nonzero value, so the first slow entry divides by eight
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            slow_q    <= '{1'b0, 1'b0, 1'b0, SCCD_SLOW_DIV_RST};
            ratio_q   <= '0;
            cam_q     <= '0;
            dp_wr_q   <= 1'b0;
            dp_addr_q <= '0;
            rdata_q   <= SCCD_ZERO_WORD;
        end else begin
            slow_q    <= slow_d;
            ratio_q   <= ratio_d;
            cam_q     <= cam_d;
            dp_wr_q   <= dp_wr_d;
            dp_addr_q <= dp_addr_d;
            rdata_q   <= rdata_d;
        end
    end

    // Core clock source; a new selection or divider only takes over at the end of the
    // running core period, so no pulse is ever cut short on a switch
    assign core_tick = slow_act_q ? (src_tick_i.input_clk && (slow_cnt_q == 4'h0))
                                  : src_tick_i.main_pll;
    always_comb begin
        slow_act_d = slow_act_q;
        slow_cnt_d = slow_cnt_q;
        if (core_tick) begin
            slow_act_d = slow_q.slow_mode_select;
            slow_cnt_d = (slow_q.slow_divider_value == 3'h0) ? 4'h0 :
                         {slow_q.slow_divider_value, 1'b0} - 4'h1;
        end else if (slow_act_q && src_tick_i.input_clk) begin
            slow_cnt_d = slow_cnt_q - 4'h1;
        end
    end

    // Main PLL powers down only while the core already runs from the slow source
    assign main_pll_power_down_o = slow_q.main_pll_power_down && slow_act_q;

    // System bus, peripheral bus and processor clock edges, reloaded at boundaries
    assign bus_tick = core_tick && (bus_cnt_q == 4'h0);
    assign per_tick = bus_tick && !per_cnt_q;
    always_comb begin
        bus_cnt_d = bus_cnt_q;
        per_cnt_d = per_cnt_q;
        cpu_bus_d = cpu_bus_q;
        if (core_tick) begin
            bus_cnt_d = (bus_cnt_q == 4'h0) ? bus_factor(ratio_q, cam_q) - 4'h1
                                            : bus_cnt_q - 4'h1;
        end
        if (bus_tick) begin
            per_cnt_d = per_cnt_q ? 1'b0 : ratio_q.peripheral_clock_ratio;
            cpu_bus_d = cam_q.core_on_bus_clock;
        end
    end

    // USB PLL power and lock wait; the wait counts input clock edges
    always_comb begin
        usb_st_d   = usb_st_q;
        lock_cnt_d = lock_cnt_q;
        unique case (usb_st_q)
            SCCD_USB_OFF: begin
                if (!slow_q.usb_clock_gate_bit) begin
                    usb_st_d   = SCCD_USB_LOCK;
                    lock_cnt_d = usb_pll_lock_count_i;
                end
            end
            SCCD_USB_LOCK: begin
                if (slow_q.usb_clock_gate_bit) begin
                    usb_st_d = SCCD_USB_OFF;
                end else if (lock_cnt_q == 16'h0000) begin
                    usb_st_d = SCCD_USB_RUN;
                end else if (src_tick_i.input_clk) begin
                    lock_cnt_d = lock_cnt_q - 16'h0001;
                end
            end
            SCCD_USB_RUN: begin
                if (slow_q.usb_clock_gate_bit) begin
                    usb_st_d = SCCD_USB_OFF;
                end
            end
        endcase
    end

    // USB PLL power follows the state register; pulses only in the run state
    assign usb_pll_power_down_o = (usb_st_q == SCCD_USB_OFF);
    assign upll_ok              = (usb_st_q == SCCD_USB_RUN) && src_tick_i.usb_pll;

    // USB and camera clocks from the USB PLL, held off until it has locked
    assign usb_tick = upll_ok && !usb_cnt_q;
    assign cam_tick = upll_ok && (cam_cnt_q == 5'h00);
    always_comb begin
        usb_cnt_d = usb_cnt_q;
        cam_cnt_d = cam_cnt_q;
        if (upll_ok) begin
            usb_cnt_d = usb_cnt_q ? 1'b0 : ratio_q.usb_clock_halve;
            if (cam_cnt_q != 5'h00) begin
                cam_cnt_d = cam_cnt_q - 5'h01;
            end else if (cam_q.camera_clock_divide_select) begin
                cam_cnt_d = {cam_q.camera_clock_divisor, 1'b1};
            end
        end
    end

    // Registered clock enables, one cycle behind their source edges
    always_comb begin
        clk_d.core_clock           = core_tick;
        clk_d.cpu_clock            = cpu_bus_q ? bus_tick : core_tick;
        clk_d.system_bus_clock     = bus_tick;
        clk_d.peripheral_bus_clock = per_tick;
        clk_d.usb_clock            = usb_tick;
        clk_d.camera_clock         = cam_tick;
    end

    assign clk_en_o = clk_q;

    // Divider, lock and enable flops; enables leave from flops so that
    // downstream gates never see a combinational glitch
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            slow_act_q <= 1'b0;
            slow_cnt_q <= 4'h0;
            bus_cnt_q  <= 4'h0;
            per_cnt_q  <= 1'b0;
            cpu_bus_q  <= 1'b0;
            usb_st_q   <= SCCD_USB_OFF;
            lock_cnt_q <= 16'h0000;
            usb_cnt_q  <= 1'b0;
            cam_cnt_q  <= 5'h00;
            clk_q      <= '0;
        end else begin
            slow_act_q <= slow_act_d;
            slow_cnt_q <= slow_cnt_d;
            bus_cnt_q  <= bus_cnt_d;
            per_cnt_q  <= per_cnt_d;
            cpu_bus_q  <= cpu_bus_d;
            usb_st_q   <= usb_st_d;
            lock_cnt_q <= lock_cnt_d;
            usb_cnt_q  <= usb_cnt_d;
            cam_cnt_q  <= cam_cnt_d;
            clk_q      <= clk_d;
        end
    end

endmodule

`default_nettype wire

/* File: hw/sccd_pkg.sv */
// Package: register map, field layouts and constants of the slow clock and divider control
package sccd_pkg;

    // Register byte addresses (low byte is decoded)
    localparam logic [31:0] SCCD_SLOW_OFS  = 32'h4C00_0010;
    localparam logic [31:0] SCCD_RATIO_OFS = 32'h4C00_0014;
    localparam logic [31:0] SCCD_CAM_OFS   = 32'h4C00_0018;
    localparam logic [31:0] SCCD_STAT_OFS  = 32'h4C00_001C;
    localparam int          SCCD_DEC_MSB   = 7;

    // Field positions
    localparam int SCCD_USB_GATE_POS  = 7;
    localparam int SCCD_MPLL_PD_POS   = 5;
    localparam int SCCD_SLOW_SEL_POS  = 4;
    localparam int SCCD_SLOW_DIV_LSB  = 0;
    localparam int SCCD_USB_HALVE_POS = 3;
    localparam int SCCD_BUS_RATIO_LSB = 1;
    localparam int SCCD_PER_RATIO_POS = 0;
    localparam int SCCD_CORE_BUS_POS  = 12;
    localparam int SCCD_QUART_HV_POS  = 9;
    localparam int SCCD_THIRD_HV_POS  = 8;
    localparam int SCCD_CAM_SEL_POS   = 4;
    localparam int SCCD_CAM_DIV_LSB   = 0;
    localparam int SCCD_ST_LOCK_POS   = 0;
    localparam int SCCD_ST_SLOW_POS   = 1;
    localparam int SCCD_ST_MOFF_POS   = 2;
    localparam int SCCD_ST_CPUBUS_POS = 3;

    // Reset values
    localparam logic [2:0] SCCD_SLOW_DIV_RST = 3'h4;

    // Bus ratio codes and the divide factors they give
    localparam logic [1:0] SCCD_BUS_DIV1 = 2'h0;
    localparam logic [1:0] SCCD_BUS_DIV2 = 2'h1;
    localparam logic [1:0] SCCD_BUS_DIV4 = 2'h2;
    localparam logic [1:0] SCCD_BUS_DIV3 = 2'h3;
    localparam logic [3:0] SCCD_F1 = 4'h1;
    localparam logic [3:0] SCCD_F2 = 4'h2;
    localparam logic [3:0] SCCD_F3 = 4'h3;
    localparam logic [3:0] SCCD_F4 = 4'h4;
    localparam logic [3:0] SCCD_F6 = 4'h6;
    localparam logic [3:0] SCCD_F8 = 4'h8;

    // AHB-Lite
    localparam int          SCCD_HTRANS_ACT = 1;
    localparam logic [31:0] SCCD_ZERO_WORD  = 32'h0000_0000;

    typedef struct packed {
        logic       usb_clock_gate_bit;
        logic       main_pll_power_down;
        logic       slow_mode_select;
        logic [2:0] slow_divider_value;
    } sccd_slow_type;

    typedef struct packed {
        logic       usb_clock_halve;
        logic [1:0] bus_clock_ratio;
        logic       peripheral_clock_ratio;
    } sccd_ratio_type;

    typedef struct packed {
        logic       core_on_bus_clock;
        logic       quarter_ratio_halve;
        logic       third_ratio_halve;
        logic       camera_clock_divide_select;
        logic [3:0] camera_clock_divisor;
    } sccd_cam_type;

    // Source clock edges, one-cycle enable pulses
    typedef struct packed {
        logic main_pll;
        logic usb_pll;
        logic input_clk;
    } sccd_src_type;

    // Derived clock edges, one-cycle enable pulses
    typedef struct packed {
        logic core_clock;
        logic cpu_clock;
        logic system_bus_clock;
        logic peripheral_bus_clock;
        logic usb_clock;
        logic camera_clock;
    } sccd_clk_type;

    typedef enum logic [1:0] {
        SCCD_USB_OFF  = 2'b00,
        SCCD_USB_LOCK = 2'b01,
        SCCD_USB_RUN  = 2'b11
    } sccd_usb_state_type;

endpackage

/* File: testbench/sccd_clock_control_asserts.sv */
// Concurrent checks on the clock enable outputs of the clock control block
`timescale 1ns/100ps
`default_nettype none
module sccd_clock_control_asserts (
    input wire logic                   sys_clk_i,
    input wire logic                   srst_i,
    input wire sccd_pkg::sccd_src_type src_tick_i,
    input wire logic [15:0]            usb_pll_lock_count_i,
    input wire sccd_pkg::sccd_clk_type clk_en_o,
    input wire logic                   usb_pll_power_down_o
);
    import sccd_pkg::*;
    logic [15:0] tick_cnt_q;
    logic [15:0] tick_cnt_d;
    logic        seen_q;
    logic        seen_d;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    // Input ticks since the USB PLL got power, frozen meaning once usb runs
    always_comb begin
        tick_cnt_d = tick_cnt_q;
        seen_d     = seen_q | clk_en_o.usb_clock;
        if (src_tick_i.input_clk && tick_cnt_q != 16'hFFFF) begin
            tick_cnt_d = tick_cnt_q + 16'h0001;
        end
        if (usb_pll_power_down_o) begin
            tick_cnt_d = 16'h0000;
            seen_d     = 1'b0;
        end
    end

    // Counter registers; saturates so a long run cannot wrap
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tick_cnt_q <= 16'h0000;
            seen_q     <= 1'b0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            seen_q     <= seen_d;
        end
    end

    a_usb_gated: assert property (usb_pll_power_down_o && $past(usb_pll_power_down_o)
        |-> !clk_en_o.usb_clock) else $error("usb pulse while USB PLL off");
    a_cam_gated: assert property (usb_pll_power_down_o [*2]
        |-> !clk_en_o.camera_clock) else $error("camera pulse while USB PLL off");
    a_core_src: assert property (clk_en_o.core_clock
        |-> $past(src_tick_i.main_pll) || $past(src_tick_i.input_clk))
        else $error("core pulse without source tick");
    a_usb_src: assert property (clk_en_o.usb_clock |-> $past(src_tick_i.usb_pll))
        else $error("usb pulse without USB PLL tick");
    a_cam_src: assert property (clk_en_o.camera_clock |-> $past(src_tick_i.usb_pll))
        else $error("camera pulse without USB PLL tick");
    a_bus_core: assert property (clk_en_o.system_bus_clock |-> clk_en_o.core_clock)
        else $error("bus pulse off a core edge");
    a_per_bus: assert property (clk_en_o.peripheral_bus_clock
        |-> clk_en_o.system_bus_clock) else $error("peripheral pulse off a bus edge");
    a_cpu_core: assert property (clk_en_o.cpu_clock |-> clk_en_o.core_clock)
        else $error("cpu pulse off a core edge");
    a_usb_lock: assert property (clk_en_o.usb_clock && !seen_q
        |-> tick_cnt_q >= usb_pll_lock_count_i) else $error("usb pulse before lock count");
endmodule
`default_nettype wire

/* File: testbench/sccd_clock_control_tb.sv */
// Register and clock enable regression of the slow clock and divider control
`timescale 1ns/100ps
`default_nettype none
module sccd_clock_control_tb;
    import sccd_pkg::*;
    localparam int          STAB_CYC = 20;  // Shortened PLL settle wait
    localparam logic [15:0] LOCK_CNT = 16'h0010;
    localparam logic [31:0] UNMAP    = 32'h4C00_0020;
    logic         sys_clk_i, srst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
    logic         main_pll_power_down_o, usb_pll_power_down_o;
    logic [31:0]  haddr_i, hwdata_i, hrdata_o, rd_q;
    logic [1:0]   htrans_i;
    sccd_src_type src_tick_i = '0;
    sccd_clk_type clk_en_o;
    int           errors, tests_run, n;
    int           tc = 0;

    sccd_clock_control DUT (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .src_tick_i(src_tick_i),
        .usb_pll_lock_count_i(LOCK_CNT), .clk_en_o(clk_en_o),
        .main_pll_power_down_o(main_pll_power_down_o),
        .usb_pll_power_down_o(usb_pll_power_down_o));

    // 200 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    // Source edges: main PLL every 2, USB PLL every 3, input clock every 5 cycles
    always @(posedge sys_clk_i) begin
        tc <= tc + 1;
        src_tick_i.main_pll  <= (tc % 2 == 0);
        src_tick_i.usb_pll   <= (tc % 3 == 0);
        src_tick_i.input_clk <= (tc % 5 == 0);
    end

    // One AHB-Lite single transfer; waits on hready in both phases
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge sys_clk_i);
        htrans_i <= 2'h2;
        haddr_i  <= a;
        hwrite_i <= wr;
        @(posedge sys_clk_i);
        while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        @(posedge sys_clk_i);
        while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
        rd_q = hrdata_o;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string nm);
        ahb(1'b0, a, SCCD_ZERO_WORD);
        chk(nm, exp, rd_q);
        chk("response", SCCD_ZERO_WORD, {31'h0, hresp_o});
    endtask

    // Measures a settled period: the first pulses may still use the old ratio
    task automatic per(input int b, input int exp, input string nm);
        int m;
        int k;
        m = 0;
        k = 0;
        while (k < 4 && m < 2000) begin
            @(posedge sys_clk_i);
            #1;
            m++;
            if (clk_en_o[b] === 1'b1) begin
                k++;
                if (k == 3) m = 0;
            end
        end
        chk(nm, exp, m);
    endtask

    task automatic cfg(input logic [31:0] r, input logic [31:0] c, input int b, input int e);
        ahb(1'b1, SCCD_RATIO_OFS, r);
        ahb(1'b1, SCCD_CAM_OFS, c);
        per(b, e, $sformatf("period of enable bit %0d", b));
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Watchdog well above the expected run length
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        errors++;
        $display("[ERR] watchdog expected done seen timeout");
        test_done();
    end

    // Main sequence
    initial begin
        srst_i = 1'b1;
        hsel_i = 1'b0;
        htrans_i = 2'h0;
        haddr_i = SCCD_ZERO_WORD;
        hwrite_i = 1'b0;
        hwdata_i = SCCD_ZERO_WORD;
        errors = 0;
        tests_run = 0;
        repeat (12) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        hsel_i <= 1'b1;
        rd(SCCD_SLOW_OFS, 32'h0000_0004, "slow reset");
        rd(SCCD_RATIO_OFS, SCCD_ZERO_WORD, "ratio reset");
        rd(SCCD_CAM_OFS, SCCD_ZERO_WORD, "camera reset");
        ahb(1'b1, SCCD_CAM_OFS, 32'h0000_131F);
        rd(SCCD_CAM_OFS, 32'h0000_131F, "camera readback");
        ahb(1'b1, UNMAP, 32'hFFFF_FFFF);
        rd(UNMAP, SCCD_ZERO_WORD, "unmapped");
        $display("test registers done");
        ahb(1'b1, SCCD_SLOW_OFS, 32'h0000_0084);
        repeat (4) @(posedge sys_clk_i);
        #1;
        chk("usb pll off", 32'h1, {31'h0, usb_pll_power_down_o});
        ahb(1'b1, SCCD_SLOW_OFS, 32'h0000_0004);
        n = 0;
        while (clk_en_o.usb_clock !== 1'b1 && n < 500) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        chk("lock wait", 32'h1, {31'h0, n >= int'(LOCK_CNT) * 5 - 5 && n < 500});
        rd(SCCD_STAT_OFS, 32'h0000_0009, "status running");
        $display("test usb gating done");
        ahb(1'b1, SCCD_SLOW_OFS, 32'h0000_0024);
        repeat (60) @(posedge sys_clk_i);
        #1;
        chk("mpll off without slow", 32'h0, {31'h0, main_pll_power_down_o});
        ahb(1'b1, SCCD_SLOW_OFS, 32'h0000_0034);
        per(5, 40, "slow core divide 4");
        chk("mpll off in slow", 32'h1, {31'h0, main_pll_power_down_o});
        rd(SCCD_STAT_OFS, 32'h0000_000F, "status slow");
        ahb(1'b1, SCCD_SLOW_OFS, 32'h0000_0010);
        per(5, 5, "slow core undivided");
        chk("mpll restarted", 32'h0, {31'h0, main_pll_power_down_o});
        ahb(1'b1, SCCD_SLOW_OFS, 32'h0000_0011);
        per(5, 10, "slow core divide 1");
        repeat (STAB_CYC) @(posedge sys_clk_i);
        ahb(1'b1, SCCD_SLOW_OFS, SCCD_ZERO_WORD);
        per(5, 2, "core from main pll");
        $display("test slow mode done");
        cfg(32'h0, 32'h0, 3, 2);
        cfg(32'h2, 32'h0, 3, 4);
        cfg(32'h4, 32'h0, 3, 8);
        cfg(32'h4, 32'h200, 3, 16);
        cfg(32'h6, 32'h0, 3, 6);
        cfg(32'h6, 32'h100, 3, 12);
        cfg(32'h3, 32'h0, 2, 8);
        cfg(32'h1, 32'h0, 2, 4);
        cfg(32'h2, 32'h1000, 4, 4);
        cfg(32'h2, 32'h0, 4, 2);
        $display("test bus ratios done");
        cfg(32'h8, 32'h0, 1, 6);
        cfg(32'h0, 32'h0, 1, 3);
        cfg(32'h0, 32'hF, 0, 3);
        cfg(32'h0, 32'h10, 0, 6);
        cfg(32'h0, 32'h1F, 0, 96);
        $display("test usb and camera done");
        test_done();
    end
endmodule

bind sccd_clock_control sccd_clock_control_asserts u_chk (.sys_clk_i(sys_clk_i),
    .srst_i(srst_i), .src_tick_i(src_tick_i), .usb_pll_lock_count_i(usb_pll_lock_count_i),
    .clk_en_o(clk_en_o), .usb_pll_power_down_o(usb_pll_power_down_o));
`default_nettype wire
